// ==== status_flag_pkg.sv ====
// Purpose: Shared constants and carriers for the unit status flag bank
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Register indices are kept; byte address is four times the index
package status_flag_pkg;

    // Register indices and address width
    localparam logic [7:0] link_fault_idx = 8'h04;
    localparam logic [7:0] input_fault_idx = 8'h05;
    localparam logic [7:0] heater_oc_idx = 8'h06;
    localparam logic [7:0] heater_alarm_idx = 8'h07;
    localparam logic [7:0] summary_idx = 8'h08;
    localparam logic [7:0] irq_status_idx = 8'h09;
    localparam logic [7:0] irq_mask_idx = 8'h0a;
    localparam logic [7:0] threshold_idx = 8'h0b;
    localparam int addr_w = 10;

    // Field positions
    localparam int summary_input_bit = 10;
    localparam int summary_alarm_bit = 12;
    localparam int alarm_one_lsb = 0;
    localparam int alarm_two_lsb = 4;

    // Reset values
    localparam logic [15:0] flags_rst = 16'h0000;
    localparam logic [3:0] irq_mask_rst = 4'h0;
    // Heater current in units of 0.1 A; 110.0 A
    localparam logic [15:0] oc_limit_rst = 16'h044c;

    // Interrupt status bits: one per status word
    localparam int irq_link = 0;
    localparam int irq_input = 1;
    localparam int irq_oc = 2;
    localparam int irq_alarm = 3;

    typedef struct packed {
        logic break_alarm;
        logic short_alarm;
        logic overcurrent_alarm;
    } heater_alarm_s;

    typedef struct packed {
        logic [7:0] link_fail;
        logic [3:0] count_err;
        logic [15:0] current_one;
        logic [15:0] current_two;
        heater_alarm_s alarm_one;
        heater_alarm_s alarm_two;
    } flag_in_s;

    typedef struct packed {
        logic [15:0] link_fault;
        logic [15:0] input_fault;
        logic [15:0] heater_oc;
        logic [15:0] heater_alarm;
    } flag_words_s;

endpackage

// ==== flag_sampler.sv ====
// Purpose: Builds the four status words from live fault inputs
// Assumes: Inputs synchronous to clk, currents in 0.1 A units
// Notes: Flags follow their sources, one cycle of latency
`timescale 1ns/1ns
module flag_sampler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sources and limit
    input wire status_flag_pkg::flag_in_s src,
    input wire logic [15:0] oc_limit,
    // Words
    output status_flag_pkg::flag_words_s words
);

    typedef struct packed {
        status_flag_pkg::flag_words_s w;
    } state_s;

    state_s state_q;
    state_s state_d;

    always_comb begin
        state_d = '0;
        state_d.w.link_fault[7:0] = src.link_fail;
        state_d.w.input_fault[3:0] = src.count_err;
        state_d.w.heater_oc[0] = src.current_one > oc_limit;
        state_d.w.heater_oc[1] = src.current_two > oc_limit;
        state_d.w.heater_alarm[status_flag_pkg::alarm_one_lsb +: 3] =
            {src.alarm_one.overcurrent_alarm, src.alarm_one.short_alarm,
             src.alarm_one.break_alarm};
        state_d.w.heater_alarm[status_flag_pkg::alarm_two_lsb +: 3] =
            {src.alarm_two.overcurrent_alarm, src.alarm_two.short_alarm,
             src.alarm_two.break_alarm};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign words = state_q.w;

    link_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        words.link_fault[7:0] == $past(src.link_fail))
        else $error("link fault word does not follow sources");
    oc_one_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
        words.heater_oc[0] == ($past(src.current_one) > $past(oc_limit)))
        else $error("first overcurrent flag wrong");
    oc_two_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
        words.heater_oc[1] == ($past(src.current_two) > $past(oc_limit)))
        else $error("second overcurrent flag wrong");
    input_follow_a: assert property (@(posedge clk)
        disable iff (!rst_n) words.input_fault[3:0] == $past(src.count_err))
        else $error("input fault word does not follow sources");

endmodule

// ==== status_flag_regs.sv ====
// Purpose: AHB-Lite slave holding the four read-only status words
// Assumes: Single word transfers, zero wait states, OKAY response
// Notes: Index registers sit at byte address index times four
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
// Functional notes
// - Link fault bits follow expansion unit failures
// - Input fault bits follow channel count errors
// - First sensor above the threshold register (reset 110.0 A) sets bit 0
// - Second sensor above the threshold register (reset 110.0 A) sets bit 1
// - Alarm bits 0-2 from first sensor
// - Alarm bits 4-6 from second sensor
// - Summary bit 10 ORs input faults
// - Summary bit 12 ORs heater flags
module status_flag_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Fault sources
    input wire status_flag_pkg::flag_in_s src,
    // Interrupt
    output logic irq
);

    typedef enum logic [3:0] {
        reg_none = 4'h0,
        reg_link = 4'h1,
        reg_input = 4'h2,
        reg_oc = 4'h3,
        reg_alarm = 4'h4,
        reg_summary = 4'h5,
        reg_irq_status = 4'h6,
        reg_irq_mask = 4'h7,
        reg_threshold = 4'h8
    } reg_sel_e;

    typedef struct packed {
        logic wr_pend;
        reg_sel_e wr_sel;
        logic [31:0] rdata;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [15:0] oc_limit;
        logic [3:0] prev_any;
    } state_s;

    state_s state_q;
    state_s state_d;
    status_flag_pkg::flag_words_s words;
    logic [15:0] summary;
    logic [3:0] any_now;
    logic [3:0] rise;
    logic take;
    reg_sel_e sel;

    // Index compare on the word address
    function automatic reg_sel_e decode(input logic [31:0] a);
        logic [7:0] idx;
        idx = a[status_flag_pkg::addr_w-1:2];
        if (a[1:0] != 2'h0) begin
            decode = reg_none;
        end else if (idx == status_flag_pkg::link_fault_idx) begin
            decode = reg_link;
        end else if (idx == status_flag_pkg::input_fault_idx) begin
            decode = reg_input;
        end else if (idx == status_flag_pkg::heater_oc_idx) begin
            decode = reg_oc;
        end else if (idx == status_flag_pkg::heater_alarm_idx) begin
            decode = reg_alarm;
        end else if (idx == status_flag_pkg::summary_idx) begin
            decode = reg_summary;
        end else if (idx == status_flag_pkg::irq_status_idx) begin
            decode = reg_irq_status;
        end else if (idx == status_flag_pkg::irq_mask_idx) begin
            decode = reg_irq_mask;
        end else if (idx == status_flag_pkg::threshold_idx) begin
            decode = reg_threshold;
        end else begin
            decode = reg_none;
        end
    endfunction

    flag_sampler u_sampler (
        .clk(clk),
        .rst_n(rst_n),
        .src(src),
        .oc_limit(state_q.oc_limit),
        .words(words)
    );

    always_comb begin
        summary = '0;
        summary[status_flag_pkg::summary_input_bit] =
            |words.input_fault;
        summary[status_flag_pkg::summary_alarm_bit] =
            |words.heater_oc | |words.heater_alarm;
    end

    assign any_now = {|words.heater_alarm, |words.heater_oc,
                      |words.input_fault, |words.link_fault};
    assign rise = any_now & ~state_q.prev_any;
    assign take = hsel && hready && htrans[1];
    assign sel = decode(haddr);

    always_comb begin
        state_d = state_q;
        state_d.prev_any = any_now;
        state_d.wr_pend = 1'b0;
        state_d.wr_sel = reg_none;
        // Data phase write; only control registers accept it
        if (state_q.wr_pend) begin
            case (state_q.wr_sel)
                reg_irq_status: begin
                    state_d.irq_status = state_q.irq_status & ~hwdata[3:0];
                end
                reg_irq_mask: begin
                    state_d.irq_mask = hwdata[3:0];
                end
                reg_threshold: begin
                    state_d.oc_limit = hwdata[15:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a same-cycle clear
        state_d.irq_status = state_d.irq_status | rise;
        if (take && hwrite) begin
            state_d.wr_pend = 1'b1;
            state_d.wr_sel = sel;
        end
        if (take && !hwrite) begin
            case (sel)
                reg_link: state_d.rdata = {16'h0000, words.link_fault};
                reg_input: state_d.rdata = {16'h0000, words.input_fault};
                reg_oc: state_d.rdata = {16'h0000, words.heater_oc};
                reg_alarm: state_d.rdata = {16'h0000, words.heater_alarm};
                reg_summary: state_d.rdata = {16'h0000, summary};
                reg_irq_status: state_d.rdata = {28'h0, state_d.irq_status};
                reg_irq_mask: state_d.rdata = {28'h0, state_q.irq_mask};
                reg_threshold: state_d.rdata = {16'h0000, state_q.oc_limit};
                default: state_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q.wr_pend <= 1'b0;
            state_q.wr_sel <= reg_none;
            state_q.rdata <= 32'h0;
            state_q.irq_status <= 4'h0;
            state_q.irq_mask <= status_flag_pkg::irq_mask_rst;
            state_q.oc_limit <= status_flag_pkg::oc_limit_rst;
            state_q.prev_any <= 4'h0;
        end else begin
            state_q <= state_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_q.rdata;
    assign irq = |(state_q.irq_status & state_q.irq_mask);

    unused_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        words.link_fault[15:8] == 8'h00 && words.input_fault[15:4] == 12'h0
        && words.heater_oc[15:2] == 14'h0
        && words.heater_alarm[3] == 1'b0
        && words.heater_alarm[15:7] == 9'h0)
        else $error("unused status bit set");
    alarm_one_map_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        words.heater_alarm[2:0] == $past({src.alarm_one.overcurrent_alarm,
        src.alarm_one.short_alarm, src.alarm_one.break_alarm}))
        else $error("first sensor alarm bits wrong");
    alarm_two_map_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        words.heater_alarm[6:4] == $past({src.alarm_two.overcurrent_alarm,
        src.alarm_two.short_alarm, src.alarm_two.break_alarm}))
        else $error("second sensor alarm bits wrong");
    summary_input_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        summary[10] == |words.input_fault)
        else $error("input summary bit wrong");
    summary_alarm_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        summary[12] == (|words.heater_oc || |words.heater_alarm))
        else $error("alarm summary bit wrong");
    word_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && !hwrite && sel == reg_link |=> hrdata[31:8] == 24'h0)
        else $error("link word read shows unused bits");
    // Mask may change in the same cycle, so check the sticky bit itself
    irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise[0] |=> state_q.irq_status[0])
        else $error("link fault event not latched");

    link_fault_c: cover property (@(posedge clk) disable iff (!rst_n)
        rise[0]);
    oc_read_c: cover property (@(posedge clk) disable iff (!rst_n)
        take && !hwrite && sel == reg_oc && words.heater_oc != 16'h0);
    irq_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(irq));

endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the status flag register bank
// Assumes: Zero wait state slave, status words lag sources by one cycle
// Notes: Reads queue their expected word; a monitor compares in data phase
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] lfsr_q = 32'h4af81aa7;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic rd_dp = 1'b0;
    status_flag_pkg::flag_in_s src = '0;
    logic [31:0] exp_q[$];
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    status_flag_regs dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .src(src), .irq(irq)
    );

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] addr(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    // Expected word i: link, input, overcurrent, alarm, summary
    function automatic logic [31:0] word(input int i,
                                         input status_flag_pkg::flag_in_s s);
        logic [15:0] lim;
        logic [31:0] w[5];
        lim = status_flag_pkg::oc_limit_rst;
        w[0] = {24'h0, s.link_fail};
        w[1] = {28'h0, s.count_err};
        w[2] = {30'h0, s.current_two > lim, s.current_one > lim};
        w[3] = {25'h0, s.alarm_two.overcurrent_alarm,
                s.alarm_two.short_alarm, s.alarm_two.break_alarm, 1'b0,
                s.alarm_one.overcurrent_alarm, s.alarm_one.short_alarm,
                s.alarm_one.break_alarm};
        w[4] = 32'h0;
        w[4][10] = |w[1];
        w[4][12] = (|w[2]) | (|w[3]);
        return w[i];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input logic exp);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // One single transfer; reads leave their expectation in the queue
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        if (!w) exp_q.push_back(d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        if (w) hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask

    task automatic rd_all();
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, addr(status_flag_pkg::link_fault_idx + 8'(i)),
                 word(i, src));
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (rd_dp) chk(hrdata, exp_q.pop_front());
        if (rd_dp) chk({31'h0, hresp}, 32'h0);
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    // Generous ceiling; the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        xfer(1'b0, addr(status_flag_pkg::irq_mask_idx), 32'h0);
        xfer(1'b0, addr(status_flag_pkg::threshold_idx), 32'h044c);
        chk_irq(1'b0);
        rd_all();
        $display("test reset done");
        // Currents straddle the limit: 0x44b..0x44e
        for (int n = 0; n < 16; n++) begin
            lfsr_q = nxt(lfsr_q);
            src.link_fail <= lfsr_q[24] ? 8'h0 : lfsr_q[7:0];
            src.count_err <= lfsr_q[25] ? 4'h0 : lfsr_q[11:8];
            src.current_one <= 16'h044b + 16'(lfsr_q[13:12]);
            src.current_two <= 16'h044b + 16'(lfsr_q[15:14]);
            src.alarm_one <= lfsr_q[26] ? 3'h0 : lfsr_q[18:16];
            src.alarm_two <= lfsr_q[26] ? 3'h0 : lfsr_q[21:19];
            repeat (2) @(posedge clk);
            rd_all();
        end
        $display("test random flags done");
        src <= '1;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, addr(status_flag_pkg::link_fault_idx + 8'(i)),
                 32'hffffffff);
        end
        xfer(1'b1, 32'h40, 32'hffffffff);
        xfer(1'b0, 32'h40, 32'h0);
        rd_all();
        $display("test write ignore done");
        src <= '0;
        repeat (3) @(posedge clk);
        xfer(1'b1, addr(status_flag_pkg::irq_status_idx), 32'hf);
        xfer(1'b0, addr(status_flag_pkg::irq_status_idx), 32'h0);
        xfer(1'b1, addr(status_flag_pkg::irq_mask_idx), 32'h2);
        src.count_err <= 4'h1;
        repeat (4) @(posedge clk);
        chk_irq(1'b1);
        xfer(1'b0, addr(status_flag_pkg::irq_status_idx), 32'h2);
        xfer(1'b1, addr(status_flag_pkg::irq_mask_idx), 32'h0);
        repeat (2) @(posedge clk);
        chk_irq(1'b0);
        xfer(1'b1, addr(status_flag_pkg::irq_status_idx), 32'h2);
        xfer(1'b1, addr(status_flag_pkg::irq_mask_idx), 32'h2);
        repeat (2) @(posedge clk);
        chk_irq(1'b0);
        xfer(1'b0, addr(status_flag_pkg::irq_status_idx), 32'h0);
        repeat (2) @(posedge clk);
        $display("test interrupt done");
        // Lowered limit must move the overcurrent compare with it
        xfer(1'b1, addr(status_flag_pkg::threshold_idx), 32'h0100);
        xfer(1'b0, addr(status_flag_pkg::threshold_idx), 32'h0100);
        src.current_one <= 16'h0101;
        repeat (2) @(posedge clk);
        xfer(1'b0, addr(status_flag_pkg::heater_oc_idx), 32'h1);
        src.current_one <= 16'h0100;
        repeat (2) @(posedge clk);
        xfer(1'b0, addr(status_flag_pkg::heater_oc_idx), 32'h0);
        repeat (2) @(posedge clk);
        $display("test threshold done");
        wrap_up();
    end
endmodule
